// file: inc/io_line_passing_map.vh
// constants for the i/o line passing sampler
`ifndef IO_LINE_PASSING_MAP_VH
`define IO_LINE_PASSING_MAP_VH
`define CLK_MHZ            250
`define MS_TICK_CYCLES     (`CLK_MHZ * 1000)
`define TICK100_MS         100
`define PWM_PERIOD_US      64
`define PWM_PERIOD_CYCLES  (`CLK_MHZ * `PWM_PERIOD_US)
`define PWM_MAX            10'h3ff
`define TIMEOUT_RESET      8'hff
`define MODE_DISABLED      2'h0
`define MODE_SIGNAL        2'h1
`define MODE_PULSE         2'h2
`define PIN_A_MODE_RESET   2'h1
`define PIN_B_MODE_RESET   2'h0
`define BROADCAST_SHORT    16'hffff
`define ALL_ONES_LONG      64'hffffffffffffffff
`define LONG_MARK          16'hffff
`define SAMPLE_W           88
`endif

// file: src/io_line_passing_sampler.v
// i/o line passing sampler: periodic sampling, output binding, timers, pulse outputs
`timescale 1ns/10ps
`include "io_line_passing_map.vh"

// -------------------------------------------------------------
// eight-word sample queue
// -------------------------------------------------------------
// head word is read straight from the array; a push shows one cycle later
module sample_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// system
	input  wire             clk,
	input  wire             reset,
	// write side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// read side
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	wire            empty = (wr_q == rd_q);
	wire            push  = in_valid && !full;
	wire            pop   = out_ready && !empty;

	assign in_ready  = !full;
	assign out_valid = !empty;

	always @* begin
		out_data = mem[rd_q[AW-1:0]];
	end

	always @(posedge clk) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
		if (reset) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // sample_fifo

// -------------------------------------------------------------
// sampler, binding filter, timers and pulse outputs
// -------------------------------------------------------------
module io_line_passing_sampler #(
	parameter MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
	// system
	input  wire        clk,
	input  wire        reset,
	// configuration
	input  wire [15:0] sample_interval,
	input  wire        sample_interval_wr,
	input  wire [63:0] bound_source_address,
	input  wire [63:0] line_output_timeout,
	input  wire [1:0]  pulse_pin_a_mode,
	input  wire [1:0]  pulse_pin_b_mode,
	input  wire [31:0] dest_addr_high,
	input  wire [31:0] dest_addr_low,
	input  wire        framed_mode,
	input  wire [7:0]  digital_in_enable,
	input  wire [1:0]  analog_enable,
	input  wire [7:0]  default_level,
	input  wire [7:0]  digital_out_enable,
	// pins and converter
	input  wire [7:0]  digital_line_pin,
	input  wire [9:0]  analog_channel_zero,
	input  wire [9:0]  analog_channel_one,
	// sample stream toward the radio
	output wire        tx_valid,
	input  wire        tx_ready,
	output wire [87:0] tx_data,
	// received i/o samples
	input  wire        rx_valid,
	input  wire [63:0] rx_source,
	input  wire        rx_long_source,
	input  wire [7:0]  rx_digital,
	input  wire [9:0]  rx_analog_zero,
	input  wire [9:0]  rx_analog_one,
	// received sample toward host
	output reg         host_valid,
	output reg  [27:0] host_data,
	// outputs
	output reg  [7:0]  digital_line_out,
	output reg  [7:0]  digital_line_oe,
	output reg         pulse_out_a,
	output reg         pulse_out_b,
	output reg  [7:0]  timeout_expired
);
	reg  [7:0]  pin_s1_q;
	reg  [7:0]  pin_s2_q;
	reg  [17:0] ms_cnt_q;
	reg  [6:0]  tick100_cnt_q;
	reg         tick100_q;
	reg  [15:0] interval_cnt_q;
	reg         push_q;
	reg  [87:0] push_data_q;
	wire        push_ready;
	reg  [7:0]  level_q;
	reg  [7:0]  tmr_q [0:7];
	reg  [9:0]  duty_a_q;
	reg  [9:0]  duty_b_q;
	reg  [13:0] pwm_cnt_q;
	wire        ms_tick = (ms_cnt_q == MS_TICK_CYCLES - 1);
	wire        any_in  = (|digital_in_enable) || (|analog_enable);
	wire        blocked = (bound_source_address == `ALL_ONES_LONG);
	wire        open_bind = (bound_source_address[15:0] == `BROADCAST_SHORT)
				&& (bound_source_address[63:16] == 48'h0);
	wire        match   = source_match(rx_source, rx_long_source, bound_source_address);
	wire        accept  = rx_valid && !blocked && (open_bind || match);
	integer     i;

	// short sources compare only the low 16 bits; the long form needs all 64 bits
	function source_match;
		input [63:0] src;
		input        long_src;
		input [63:0] bound;
		begin
			if (long_src)
				source_match = (src == bound);
			else
				source_match = (src[15:0] == bound[15:0]);
		end
	endfunction

	// pulse mode decode, shared by duty capture and the output stage
	function is_pulse;
		input [1:0] mode;
		begin
			is_pulse = (mode == `MODE_PULSE);
		end
	endfunction

	// reload only when the passed level leaves the default; zero leaves it idle
	function [7:0] timer_load;
		input       level;
		input       dflt;
		input [7:0] tmo;
		begin
			timer_load = (level != dflt) ? tmo : 8'h0;
		end
	endfunction

	// duty compare: cnt/period < duty/1023, so full scale holds the pin high
	function pwm_level;
		input [9:0]  duty;
		input [13:0] cnt;
		begin
			pwm_level = (({10'h0, cnt} * {14'h0, `PWM_MAX})
				< ({14'h0, duty} * `PWM_PERIOD_CYCLES));
		end
	endfunction

	// -------------------------------------------------------------
	// timebase and pin synchronisers
	// -------------------------------------------------------------
	always @(posedge clk) begin
		pin_s1_q <= digital_line_pin;
		pin_s2_q <= pin_s1_q;
		if (reset) begin
			ms_cnt_q      <= 18'h0;
			tick100_cnt_q <= 7'h0;
			tick100_q     <= 1'b0;
			pwm_cnt_q     <= 14'h0;
		end else begin
			ms_cnt_q  <= ms_tick ? 18'h0 : ms_cnt_q + 18'h1;
			tick100_q <= 1'b0;
			if (ms_tick) begin
				if (tick100_cnt_q == `TICK100_MS - 1) begin
					tick100_cnt_q <= 7'h0;
					tick100_q     <= 1'b1;
				end else
					tick100_cnt_q <= tick100_cnt_q + 7'h1;
			end
			pwm_cnt_q <= (pwm_cnt_q == `PWM_PERIOD_CYCLES - 1) ? 14'h0 : pwm_cnt_q + 14'h1;
		end
	end

	// -------------------------------------------------------------
	// periodic sampler
	// -------------------------------------------------------------
	// word: dest high/low, enables, digital, both analog channels
	always @(posedge clk) begin
		if (reset) begin
			interval_cnt_q <= 16'h0;
			push_q         <= 1'b0;
			push_data_q    <= 88'h0;
		end else begin
			push_q <= 1'b0;
			if (sample_interval_wr)
				interval_cnt_q <= 16'h0;
			else if (sample_interval != 16'h0 && any_in && ms_tick) begin
				if (interval_cnt_q + 16'h1 >= sample_interval) begin
					interval_cnt_q <= 16'h0;
					// one-cycle push: a full queue loses the sample rather than stall
					push_q      <= 1'b1;
					push_data_q <= {10'h0, dest_addr_high[15:0], dest_addr_low[31:0],
						analog_enable, pin_s2_q & digital_in_enable,
						analog_enable[0] ? analog_channel_zero : 10'h0,
						analog_enable[1] ? analog_channel_one : 10'h0};
				end else
					interval_cnt_q <= interval_cnt_q + 16'h1;
			end
		end
	end

	sample_fifo #(
		.WIDTH (`SAMPLE_W),
		.DEPTH (8),
		.AW    (3)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (push_q),
		.in_ready  (push_ready),
		.in_data   (push_data_q),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	// -------------------------------------------------------------
	// received sample toward host
	// -------------------------------------------------------------
	// only framed hosts can parse a sample, so others never see one
	always @(posedge clk) begin
		if (reset) begin
			host_valid <= 1'b0;
			host_data  <= 28'h0;
		end else begin
			host_valid <= rx_valid && framed_mode;
			if (rx_valid && framed_mode)
				host_data <= {rx_digital, rx_analog_zero, rx_analog_one};
		end
	end

	// -------------------------------------------------------------
	// line passing, timeouts, pulse outputs
	// -------------------------------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			level_q         <= 8'h0;
			duty_a_q        <= 10'h0;
			duty_b_q        <= 10'h0;
			timeout_expired <= 8'h0;
			for (i = 0; i < 8; i = i + 1)
				tmr_q[i] <= 8'h0;
		end else begin
			timeout_expired <= 8'h0;
			for (i = 0; i < 8; i = i + 1) begin
				if (accept) begin
					if (digital_out_enable[i]) begin
						level_q[i] <= rx_digital[i];
						tmr_q[i] <= timer_load(rx_digital[i], default_level[i],
							line_output_timeout[8*i +: 8]);
					end
				end else if (tick100_q && tmr_q[i] != 8'h0) begin
					tmr_q[i] <= tmr_q[i] - 8'h1;
					if (tmr_q[i] == 8'h1) begin
						timeout_expired[i] <= 1'b1;
						level_q[i]         <= default_level[i];
					end
				end
			end
			// zero load leaves the timer idle, holding the level
			if (accept && is_pulse(pulse_pin_a_mode))
				duty_a_q <= rx_analog_zero;
			if (accept && is_pulse(pulse_pin_b_mode))
				duty_b_q <= rx_analog_one;
		end
	end

	// -------------------------------------------------------------
	// pin drivers
	// -------------------------------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			digital_line_out <= 8'h0;
			digital_line_oe  <= 8'h0;
			pulse_out_a      <= 1'b0;
			pulse_out_b      <= 1'b0;
		end else begin
			digital_line_out <= level_q;
			digital_line_oe  <= digital_out_enable;
			pulse_out_a      <= is_pulse(pulse_pin_a_mode) && pwm_level(duty_a_q, pwm_cnt_q);
			pulse_out_b      <= is_pulse(pulse_pin_b_mode) && pwm_level(duty_b_q, pwm_cnt_q);
		end
	end
endmodule // io_line_passing_sampler

// file: sim/io_line_passing_checker.sv
// port assertions for the i/o line passing sampler
`timescale 1ns/10ps
module io_line_passing_checker (
	input wire        clk,
	input wire        reset,
	input wire [15:0] sample_interval,
	input wire [63:0] bound_source_address,
	input wire [63:0] line_output_timeout,
	input wire [1:0]  pulse_pin_a_mode,
	input wire [1:0]  pulse_pin_b_mode,
	input wire [7:0]  digital_in_enable,
	input wire [1:0]  analog_enable,
	input wire [7:0]  digital_out_enable,
	input wire        framed_mode,
	input wire        rx_valid,
	input wire [7:0]  rx_digital,
	input wire [9:0]  rx_analog_zero,
	input wire [9:0]  rx_analog_one,
	input wire        tx_valid,
	input wire        host_valid,
	input wire [27:0] host_data,
	input wire [7:0]  digital_line_out,
	input wire        pulse_out_a,
	input wire        pulse_out_b,
	input wire [7:0]  timeout_expired
);
	// lines whose timeout is zero
	logic [7:0] zmask;
	always_comb
		for (int i = 0; i < 8; i++)
			zmask[i] = line_output_timeout[8*i +: 8] == 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_host_framed: assert property (host_valid |-> $past(rx_valid && framed_mode))
		else $error("host sample without framed receive");
	a_host_data: assert property (host_valid |->
		host_data == $past({rx_digital, rx_analog_zero, rx_analog_one}))
		else $error("host sample data differs from received");
	a_pin_a_off: assert property ((pulse_pin_a_mode != 2'h2)[*3] |-> !pulse_out_a)
		else $error("pulse a active outside pulse mode");
	a_pin_b_off: assert property ((pulse_pin_b_mode != 2'h2)[*3] |-> !pulse_out_b)
		else $error("pulse b active outside pulse mode");
	a_expire_once: assert property ((timeout_expired & $past(timeout_expired)) == 8'h00)
		else $error("expiry longer than one cycle");
	a_zero_hold: assert property ($stable(line_output_timeout) |->
		(timeout_expired & zmask) == 8'h00)
		else $error("expiry on a line with zero timeout");
	a_tx_start: assert property ($rose(tx_valid) |-> $past(sample_interval != 16'h0
		&& (|{digital_in_enable, analog_enable}), 2))
		else $error("sample queued while sampling is off");
	a_bind_open: assert property (rx_valid && bound_source_address == 64'hffff
		&& line_output_timeout == 64'h0 |-> ##2
		((digital_line_out ^ $past(rx_digital, 2)) & digital_out_enable) == 8'h00)
		else $error("open bind did not pass levels");
	a_bind_closed: assert property (rx_valid && (&bound_source_address)
		&& line_output_timeout == 64'h0 |-> ##2 $stable(digital_line_out))
		else $error("blocked packet changed outputs");
endmodule // io_line_passing_checker

// file: sim/remote_radio_model.sv
// far radio end: drains the sample stream, can stall
`timescale 1ns/10ps
module remote_radio_model (
	input  wire         clk,
	input  wire         tx_valid,
	output logic        tx_ready,
	input  wire  [87:0] tx_data,
	input  wire         stall,
	output int          pops,
	output logic [87:0] last_word
);
	initial pops = 0;
	initial tx_ready = 1'b0;
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			pops <= pops + 1;
			last_word <= tx_data;
		end
		tx_ready <= !stall;
	end
endmodule // remote_radio_model

// file: sim/io_line_passing_sampler_tb.sv
// testbench for the i/o line passing sampler
`timescale 1ns/10ps
module io_line_passing_sampler_tb;
	logic clk = 0, reset = 1, sample_interval_wr = 0, framed_mode = 0, rx_valid = 0;
	logic rx_long_source = 0, stall = 1, tx_ready, tx_valid, host_valid, pulse_out_a, pulse_out_b;
	logic [15:0] sample_interval = 16'h0;
	logic [63:0] bound_source_address = '1, line_output_timeout = 64'h0, rx_source = 64'h1234;
	logic [1:0]  pulse_pin_a_mode = 2'h1, pulse_pin_b_mode = 2'h0, analog_enable = 2'h0;
	logic [31:0] dest_addr_high = 32'hbeef, dest_addr_low = 32'h13572468;
	logic [7:0]  digital_in_enable = 8'h0, default_level = 8'h0, digital_out_enable = 8'hff;
	logic [7:0]  digital_line_pin = 8'h0f, rx_digital = 8'h0;
	logic [7:0]  digital_line_out, digital_line_oe, timeout_expired;
	logic [9:0]  analog_channel_zero = 10'h155, analog_channel_one = 10'h2aa;
	logic [9:0]  rx_analog_zero = 10'h0, rx_analog_one = 10'h0;
	logic [87:0] tx_data, last_word;
	logic [27:0] host_data;
	int          pops, n, error_cnt = 0, samples_checked = 0;
	io_line_passing_sampler #(.MS_TICK_CYCLES(10)) uut (.*);
	remote_radio_model rr (.*);
	always #2 clk = ~clk;
	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [87:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic [9:0] a0, a1);
		rx_digital <= d;
		rx_analog_zero <= a0;
		rx_analog_one <= a1;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic set_rate(input logic [15:0] v);
		sample_interval <= v;
		sample_interval_wr <= 1'b1;
		@(posedge clk);
		sample_interval_wr <= 1'b0;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task t_bind;
		bound_source_address <= 64'hffff;
		pulse_pin_a_mode <= 2'h2;
		pulse_pin_b_mode <= 2'h2;
		framed_mode <= 1'b1;
		@(posedge clk);
		send(8'ha5, 10'h3ff, 10'h000);
		chk({digital_line_out, pulse_out_a, pulse_out_b}, {8'ha5, 2'b10});
		chk(digital_line_oe, 8'hff);
		bound_source_address <= '1;
		framed_mode <= 1'b0;
		@(posedge clk);
		send(8'h5a, 10'h0, 10'h3ff);
		chk({digital_line_out, pulse_out_a, pulse_out_b}, {8'ha5, 2'b10});
		$display("bind test done");
	endtask
	task t_timeout;
		bound_source_address <= 64'hffff;
		line_output_timeout <= 64'h2;
		@(posedge clk);
		send(8'h01, 10'h0, 10'h0);
		repeat (900) @(posedge clk);
		send(8'h01, 10'h0, 10'h0);
		n = 4;
		while (timeout_expired[0] !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk(n >= 990 && n <= 2010, 1'b1);
		repeat (3) @(posedge clk);
		chk(digital_line_out[0], 1'b0);
		line_output_timeout <= 64'h0;
		$display("timeout test done");
	endtask
	task t_sample;
		digital_in_enable <= 8'h0f;
		analog_enable <= 2'h3;
		set_rate(16'h3);
		repeat (400) @(posedge clk);
		set_rate(16'h0);
		stall <= 1'b0;
		repeat (20) @(posedge clk);
		chk(pops, 8);
		chk(last_word[77:0], {dest_addr_high[15:0], dest_addr_low, 2'h3, 8'h0f,
			10'h155, 10'h2aa});
		digital_in_enable <= 8'h0;
		analog_enable <= 2'h0;
		set_rate(16'h14);
		repeat (400) @(posedge clk);
		chk({tx_valid, pops}, {1'b0, 32'd8});
		set_rate(16'h0);
		$display("sample test done");
	endtask
	initial begin
		repeat (7) @(posedge clk);
		@(negedge clk);
		chk({tx_valid, host_valid, digital_line_out, digital_line_oe, timeout_expired}, 0);
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_bind;
		t_timeout;
		t_sample;
		complete_run;
	end
	initial begin
		#100000;
		error_cnt++;
		complete_run;
	end
endmodule // io_line_passing_sampler_tb
bind io_line_passing_sampler io_line_passing_checker chk_i (.*);
